// File: mcpt_timer.sv
// parameterised timer core: counter, channels, encoder, debug, link
`timescale 1ns/1ps
`include "mcpt_map.svh"
module mcpt_timer #(
    parameter int CNT_W    = 16,
    parameter int PSC_W    = 16,
    parameter int NUM_CH   = 4,
    parameter int NUM_COMP = 0,
    parameter bit HAS_DOWN = 1'b1
) (
    input  wire logic                                 CLK,
    input  wire logic                                 ARST_N,
    input  wire logic                                 CNT_EN,
    input  wire mcpt_pkg::mcpt_cntmode_t              CNT_MODE,
    input  wire logic                                 ONE_PULSE,
    input  wire logic [PSC_W-1:0]                     PSC_DIV,
    input  wire logic [CNT_W-1:0]                     RELOAD,
    input  wire logic                                 ENC_A,
    input  wire logic                                 ENC_B,
    input  wire mcpt_pkg::mcpt_chmode_t [NUM_CH-1:0]  CH_MODE,
    input  wire logic [NUM_CH-1:0][CNT_W-1:0]         CMP_VAL,
    input  wire logic [NUM_CH-1:0]                    CH_IN,
    input  wire logic [NUM_CH-1:0]                    CAPT_CLR,
    input  wire logic [`MCPT_DT_W-1:0]                DEAD_TIME,
    input  wire logic                                 DBG_HALT,
    input  wire logic                                 DBG_FREEZE,
    input  wire logic                                 DBG_OUT_OFF,
    input  wire logic                                 TRIG_IN,
    input  wire logic                                 TRIG_RST_EN,
    input  wire logic                                 UPD_CLR,
    input  wire logic                                 UPD_IRQ_EN,
    input  wire logic                                 UPD_DMA_EN,
    output wire logic [CNT_W-1:0]                     CNT_VALUE,
    output wire logic                                 UPDATE_FLAG,
    output wire logic                                 UPD_EVT,
    output wire logic                                 IRQ_REQ,
    output wire logic                                 DMA_REQ,
    output wire logic                                 TRIG_OUT,
    output wire logic                                 DAC_TRIG,
    output wire logic [NUM_CH-1:0]                    CH_OUT,
    output wire logic [NUM_CH-1:0]                    CH_OUT_N,
    output wire logic [NUM_CH-1:0][CNT_W-1:0]         CAPT_VAL,
    output wire logic [NUM_CH-1:0]                    CAPT_FLAG
);
    import mcpt_pkg::*;

    localparam logic [31:0] CMASK = 32'hffff_ffff >> (32 - CNT_W);
    localparam logic [31:0] PMASK = 32'hffff_ffff >> (32 - PSC_W);

    mcpt_core_t    q, d;
    logic          frozen, outs_off, run, tick, wrap, enc_dn, trig_rst;
    logic [31:0]   rld, pdiv;
    mcpt_cntmode_t mode;

    // debug halt, link trigger and effective counting mode
    assign frozen   = DBG_HALT & DBG_FREEZE; // R9
    assign outs_off = DBG_HALT & DBG_OUT_OFF; // R9
    assign trig_rst = TRIG_RST_EN & TRIG_IN & ~q.trig_q; // R11
    assign rld      = 32'(RELOAD);
    assign pdiv     = 32'(PSC_DIV) & PMASK;
    assign run      = CNT_EN & ~frozen & ~q.stopped;
    assign mode     = HAS_DOWN ? CNT_MODE : CNT_EDGE_UP; // R3
    assign enc_dn   = q.enc_a ^ ENC_B;

    // next state of the counter, prescaler, flags and channels
    always_comb begin
        d         = q;
        tick      = 1'b0;
        wrap      = 1'b0;
        d.upd_pls = 1'b0;
        d.irq_pls = 1'b0;
        d.dma_pls = 1'b0;
        d.trig_q  = TRIG_IN;
        d.enc_a   = ENC_A;
        d.enc_b   = ENC_B;
        d.in_q    = '0;
        d.in_q[NUM_CH-1:0] = CH_IN;
        if (!CNT_EN) begin
            d.stopped = 1'b0;
        end
        // tick source: quadrature edges or the prescaler
        if (mode == CNT_ENCODER) begin
            tick = run & ((ENC_A ^ q.enc_a) ^ (ENC_B ^ q.enc_b)); // R10
        end else if (run) begin
            if (q.psc >= pdiv) begin
                d.psc = `MCPT_PSC_RST; // R1 R2 R3
                tick  = 1'b1;
            end else begin
                d.psc = (q.psc + 32'h1) & PMASK;
            end
        end
        // counter step and wrap detection
        if (tick) begin
            case (mode)
                CNT_EDGE_UP: begin
                    if (q.cnt >= rld) begin
                        d.cnt = `MCPT_CNT_RST; // R13
                        wrap  = 1'b1;
                    end else begin
                        d.cnt = q.cnt + 32'h1;
                    end
                end
                CNT_EDGE_DOWN: begin
                    if (q.cnt == 32'h0) begin
                        d.cnt = rld; // R13
                        wrap  = 1'b1;
                    end else begin
                        d.cnt = q.cnt - 32'h1;
                    end
                end
                CNT_CENTER: begin
                    if (rld == 32'h0) begin
                        d.cnt = 32'h0;
                        wrap  = 1'b1;
                    end else if (!q.down && q.cnt >= rld) begin
                        d.down = 1'b1; // R7
                        d.cnt  = rld - 32'h1;
                        wrap   = 1'b1;
                    end else if (q.down && q.cnt == 32'h0) begin
                        d.down = 1'b0; // R7
                        d.cnt  = 32'h1;
                        wrap   = 1'b1;
                    end else begin
                        d.cnt = q.down ? q.cnt - 32'h1 : q.cnt + 32'h1;
                    end
                end
                CNT_ENCODER: begin
                    if (enc_dn) begin
                        wrap  = (q.cnt == 32'h0);
                        d.cnt = wrap ? rld : q.cnt - 32'h1; // R10
                    end else begin
                        wrap  = (q.cnt >= rld);
                        d.cnt = wrap ? 32'h0 : q.cnt + 32'h1; // R10
                    end
                end
                default: d.cnt = q.cnt;
            endcase
            d.cnt = d.cnt & CMASK;
        end
        // slave reset from the link overrides the step
        if (trig_rst) begin
            d.cnt  = `MCPT_CNT_RST; // R11
            d.psc  = `MCPT_PSC_RST;
            d.down = 1'b0;
        end
        // update event: sticky flag, set wins over clear
        if (wrap) begin
            d.upd_pls  = 1'b1; // R13 R12
            d.upd_flag = 1'b1;
            d.irq_pls  = UPD_IRQ_EN;
            d.dma_pls  = UPD_DMA_EN; // R10
            d.stopped  = ONE_PULSE; // R4
        end else if (UPD_CLR) begin
            d.upd_flag = 1'b0;
        end
        // channels: capture, toggle on match, pwm level
        for (int i = 0; i < NUM_CH; i++) begin
            case (CH_MODE[i])
                CH_CAPTURE: begin
                    d.oc[i] = 1'b0;
                    if (CH_IN[i] && !q.in_q[i]) begin
                        d.capt[i]      = q.cnt; // R4
                        d.capt_flag[i] = 1'b1;
                    end else if (CAPT_CLR[i]) begin
                        d.capt_flag[i] = 1'b0;
                    end
                end
                CH_COMPARE: begin
                    if (tick && q.cnt == 32'(CMP_VAL[i])) begin
                        d.oc[i] = ~q.oc[i]; // R4
                    end
                end
                CH_PWM: d.oc[i] = (d.cnt < 32'(CMP_VAL[i])); // R7
                default: d.oc[i] = 1'b0;
            endcase
            if (outs_off) begin
                d.oc[i] = 1'b0; // R9
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // channel outputs, with dead-time pairs on the low channels
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            assign CAPT_VAL[g]  = q.capt[g][CNT_W-1:0];
            assign CAPT_FLAG[g] = q.capt_flag[g];
            if (g < NUM_COMP) begin : g_pair
                mcpt_dt_if dt ();
                assign dt.ref_lvl   = q.oc[g];
                assign dt.force_off = outs_off; // R9
                assign dt.dead      = DEAD_TIME;
                mcpt_deadtime u_dt (
                    .clk    (CLK),
                    .arst_n (ARST_N),
                    .dt     (dt.gen)
                ); // R5 R6 R8
                assign CH_OUT[g]   = dt.out;
                assign CH_OUT_N[g] = dt.outn;
            end else begin : g_single
                assign CH_OUT[g]   = q.oc[g];
                assign CH_OUT_N[g] = 1'b0;
            end
        end
    endgenerate

    // status and event outputs
    assign CNT_VALUE   = q.cnt[CNT_W-1:0];
    assign UPDATE_FLAG = q.upd_flag;
    assign UPD_EVT     = q.upd_pls;
    assign IRQ_REQ     = q.irq_pls;
    assign DMA_REQ     = q.dma_pls;
    assign TRIG_OUT    = q.upd_pls; // R11
    assign DAC_TRIG    = q.upd_pls; // R12

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    a_upd_flag_set: assert property (UPD_EVT |-> UPDATE_FLAG) // R13
        else $error("update event without update flag");
    a_flag_set_wins: assert property (wrap && UPD_CLR |=> UPDATE_FLAG) // R13
        else $error("update flag lost to a clear");
    a_up_wrap_zero: assert property (
        tick && mode == CNT_EDGE_UP && q.cnt >= rld && !trig_rst
        |=> CNT_VALUE == '0 ##0 UPD_EVT) // R1
        else $error("up count did not wrap to zero");
    a_down_wrap_rld: assert property (
        tick && mode == CNT_EDGE_DOWN && q.cnt == 0 && !trig_rst
        |=> 32'(CNT_VALUE) == $past(rld)) // R2
        else $error("down count did not reload");
    a_psc_tick: assert property (
        run && mode != CNT_ENCODER && q.psc >= pdiv |-> tick) // R3
        else $error("prescaler limit gave no tick");
    a_dbg_freeze: assert property (
        frozen && !trig_rst |=> $stable(CNT_VALUE)) // R9
        else $error("counter moved while frozen");
    a_dbg_outs_off: assert property (
        outs_off |=> (CH_OUT == '0 && CH_OUT_N == '0)) // R9
        else $error("outputs active during debug halt");
    a_capt_value: assert property (
        CH_MODE[0] == CH_CAPTURE && CH_IN[0] && !q.in_q[0]
        |=> CAPT_FLAG[0] && CAPT_VAL[0] == $past(CNT_VALUE)) // R4
        else $error("capture missed counter value");
    a_pwm_zero_off: assert property (
        CH_MODE[0] == CH_PWM && CMP_VAL[0] == '0 |=> !q.oc[0]) // R7
        else $error("zero duty drove the output");
    a_link_reset: assert property (trig_rst |=> CNT_VALUE == '0) // R11
        else $error("link trigger did not reset the counter");
    a_opm_stop: assert property (
        wrap && ONE_PULSE && CNT_EN |=> ##1 $stable(CNT_VALUE)) // R4
        else $error("one-pulse counter kept running");
    c_center_turn: cover property (mode == CNT_CENTER && wrap && q.down);
    c_capture: cover property (CAPT_FLAG[0] && CAPT_CLR[0]);
    c_encoder_down: cover property (mode == CNT_ENCODER && tick && enc_dn);
endmodule : mcpt_timer

// File: mcpt_map.svh
// constants of the multi-channel pwm timer
// Operation
// R1: wide variant: 32-bit up/down counter, prescaler
// R2: narrow variant: 16-bit up/down counter, prescaler
// R3: small variants: 16-bit up-only counters, prescaler
// R4: full timers: four capture/compare/pwm/one-pulse channels
// R5: two-channel variant: one complementary output
// R6: single-channel variant: one complementary output
// R7: pwm edge or centre aligned, 0-100%
// R8: complementary pairs with programmable dead-time
// R9: debug halt freezes counter, disables outputs
// R10: full timers: dma requests, quadrature encoder
// R11: trigger link between timers
// R12: basic timers trigger converter, time base
// R13: wrap reloads, flags update, requests irq/dma
`ifndef MCPT_MAP_SVH
`define MCPT_MAP_SVH
`define MCPT_MAX_W   32
`define MCPT_MAX_CH  4
`define MCPT_DT_W    8
`define MCPT_CNT_RST 32'h0000_0000
`define MCPT_PSC_RST 32'h0000_0000
`define MCPT_DT_RST  8'h00
`endif

// File: mcpt_pkg.sv
// types of the multi-channel pwm timer
`include "mcpt_map.svh"
package mcpt_pkg;
    typedef enum logic [1:0] {
        CNT_EDGE_UP, CNT_EDGE_DOWN, CNT_CENTER, CNT_ENCODER
    } mcpt_cntmode_t;
    typedef enum logic [1:0] {
        CH_OFF, CH_CAPTURE, CH_COMPARE, CH_PWM
    } mcpt_chmode_t;
    typedef struct packed {
        logic [`MCPT_MAX_W-1:0]                      cnt;
        logic [`MCPT_MAX_W-1:0]                      psc;
        logic                                        down;
        logic                                        stopped;
        logic                                        upd_flag;
        logic                                        upd_pls;
        logic                                        irq_pls;
        logic                                        dma_pls;
        logic                                        trig_q;
        logic                                        enc_a;
        logic                                        enc_b;
        logic [`MCPT_MAX_CH-1:0]                     in_q;
        logic [`MCPT_MAX_CH-1:0]                     oc;
        logic [`MCPT_MAX_CH-1:0]                     capt_flag;
        logic [`MCPT_MAX_CH-1:0][`MCPT_MAX_W-1:0]    capt;
    } mcpt_core_t;
    typedef struct packed {
        logic                    ref_q;
        logic [`MCPT_DT_W-1:0]   cnt;
        logic                    out;
        logic                    outn;
    } mcpt_dt_t;
endpackage : mcpt_pkg

// File: mcpt_dt_if.sv
// link between the counter core and one dead-time generator
`timescale 1ns/1ps
`include "mcpt_map.svh"
interface mcpt_dt_if;
    logic                  ref_lvl;
    logic                  force_off;
    logic [`MCPT_DT_W-1:0] dead;
    logic                  out;
    logic                  outn;
    modport core (output ref_lvl, output force_off, output dead,
                  input out, input outn);
    modport gen  (input ref_lvl, input force_off, input dead,
                  output out, output outn);
endinterface : mcpt_dt_if

// File: mcpt_deadtime.sv
// complementary output pair with dead-time insertion
`timescale 1ns/1ps
`include "mcpt_map.svh"
module mcpt_deadtime (
    input wire logic clk,
    input wire logic arst_n,
    mcpt_dt_if.gen   dt
);
    import mcpt_pkg::*;
    mcpt_dt_t q, d;

    // any edge of the reference drops both legs, then waits dead+1 cycles
    always_comb begin
        d = q;
        d.ref_q = dt.ref_lvl;
        if (dt.force_off) begin
            d.out  = 1'b0; // R9
            d.outn = 1'b0;
            d.cnt  = dt.dead;
        end else if (dt.ref_lvl != q.ref_q) begin
            d.out  = 1'b0; // R8
            d.outn = 1'b0;
            d.cnt  = dt.dead;
        end else if (q.cnt != '0) begin
            d.cnt = q.cnt - 1'b1; // R8
        end else begin
            d.out  = q.ref_q;
            d.outn = ~q.ref_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '{ref_q: 1'b0, cnt: `MCPT_DT_RST, out: 1'b0, outn: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign dt.out  = q.out;
    assign dt.outn = q.outn;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_dt_no_overlap: assert property (!(q.out && q.outn)) // R8
        else $error("both legs of a complementary pair high");
    a_dt_gap_before: assert property (
        $rose(q.out) |-> !$past(q.outn) && !q.outn) // R8
        else $error("output rose without a gap after its complement");
    c_dt_rise: cover property ($rose(q.out) && dt.dead > 8'h01);
endmodule : mcpt_deadtime

// File: mcpt_src_model.sv
// far-side sources for the timer: encoder, capture pins, link trigger
`timescale 1ns/1ps
module mcpt_src_model (
    input  wire logic  clk,
    output logic       enc_a,
    output logic       enc_b,
    output logic [3:0] ch_in,
    output logic       trig
);
    int ph = 0;

    // lines idle low until a scenario asks for activity
    initial begin
        enc_a = 1'b0;
        enc_b = 1'b0;
        ch_in = 4'h0;
        trig  = 1'b0;
    end

    // one quadrature step; gray order 00,10,11,01 counts up
    task step(input int dir);
        @(posedge clk);
        ph = (ph + dir) & 3;
        enc_a <= (ph == 1) || (ph == 2);
        enc_b <= (ph == 2) || (ph == 3);
        @(posedge clk);
    endtask : step

    // one-cycle high pulse on a capture pin, or the trigger for 4
    task pulse(input int ch);
        @(posedge clk);
        if (ch < 4) ch_in[ch] <= 1'b1;
        else trig <= 1'b1;
        @(posedge clk);
        ch_in <= 4'h0;
        trig  <= 1'b0;
    endtask : pulse
endmodule : mcpt_src_model

// File: tb_top.sv
// self-checking bench of the multi-channel pwm timer core
`timescale 1ns/1ps
module tb_top;
    import mcpt_pkg::*;
    logic               clk, arst_n, en, one, halt, frz, off;
    logic               trst, uclr, irq_en, dma_en, enc_a, enc_b, trig;
    mcpt_cntmode_t      mode;
    mcpt_chmode_t [3:0] chm;
    logic [15:0]        psc, rel, cnt;
    logic [3:0][15:0]   cmp, cv;
    logic [3:0]         cclr, ch_in, o, on, cf;
    logic [7:0]         dead;
    logic               upd, uevt, irq, dma, tout, dac;
    int                 failures, comparisons;

    mcpt_timer #(.NUM_COMP(1)) i_dut (
        .CLK(clk), .ARST_N(arst_n), .CNT_EN(en), .CNT_MODE(mode),
        .ONE_PULSE(one), .PSC_DIV(psc), .RELOAD(rel), .ENC_A(enc_a),
        .ENC_B(enc_b), .CH_MODE(chm), .CMP_VAL(cmp), .CH_IN(ch_in),
        .CAPT_CLR(cclr), .DEAD_TIME(dead), .DBG_HALT(halt),
        .DBG_FREEZE(frz), .DBG_OUT_OFF(off), .TRIG_IN(trig),
        .TRIG_RST_EN(trst), .UPD_CLR(uclr), .UPD_IRQ_EN(irq_en),
        .UPD_DMA_EN(dma_en), .CNT_VALUE(cnt), .UPDATE_FLAG(upd),
        .UPD_EVT(uevt), .IRQ_REQ(irq), .DMA_REQ(dma), .TRIG_OUT(tout),
        .DAC_TRIG(dac), .CH_OUT(o), .CH_OUT_N(on), .CAPT_VAL(cv),
        .CAPT_FLAG(cf)
    );
    mcpt_src_model i_src (
        .clk(clk), .enc_a(enc_a), .enc_b(enc_b), .ch_in(ch_in), .trig(trig)
    );

    // compare and count
    task chk(input logic [63:0] s, input logic [63:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("wrong value at %0t ns: seen %0h, expected %0h",
                     $time, s, e);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // cycles until the next update pulse, bounded
    task wupd(output int n);
        n = 0;
        do begin
            cyc(1);
            #1;
            n++;
        end while (uevt !== 1'b1 && n < 5000);
    endtask : wupd

    // stop, program mode, prescaler and limit, restart
    task cfg(input mcpt_cntmode_t m, input logic [15:0] p, r);
        cyc(1);
        en <= 1'b0;
        mode <= m;
        psc <= p;
        rel <= r;
        cyc(2);
        en <= 1'b1;
    endtask : cfg

    // update period, and counter value at the update except in centre mode
    task per(input mcpt_cntmode_t m, input int p, r, ne,
             input logic [15:0] ce);
        int n;
        cfg(m, p[15:0], r[15:0]);
        wupd(n);
        wupd(n);
        chk(n, ne);
        if (m != CNT_CENTER) chk(cnt, ce);
    endtask : per

    task t_period;
        int n;
        per(CNT_EDGE_UP, 1, 2, 6, 16'h0);
        chk({irq, dma, tout, dac, upd}, 5'h1f);
        cyc(1);
        irq_en <= 1'b0;
        #1 chk(uevt, 1'b0);
        wupd(n);
        chk({irq, dma}, 2'b01);
        cyc(1);
        irq_en <= 1'b1;
        uclr <= 1'b1;
        cyc(1);
        uclr <= 1'b0;
        #1 chk(upd, 1'b0);
        // a clear held across a wrap loses to the set
        cyc(1);
        uclr <= 1'b1;
        wupd(n);
        chk(upd, 1'b1);
        cyc(1);
        uclr <= 1'b0;
        #1 chk(upd, 1'b0);
        per(CNT_EDGE_UP, 2, 5, 18, 16'h0);
        per(CNT_EDGE_DOWN, 0, 3, 4, 16'h3);
        per(CNT_CENTER, 0, 4, 4, 16'h0);
        $display("period test done");
    endtask : t_period

    // pwm duty at 0, 100 and 30 percent; compare toggles once a period
    task t_pwm;
        int h[4];
        int tg;
        logic p0;
        cyc(1);
        chm <= '{CH_PWM, CH_PWM, CH_COMPARE, CH_PWM};
        cmp <= '{16'h3, 16'ha, 16'h5, 16'h0};
        cfg(CNT_EDGE_UP, 16'h0, 16'h9);
        wupd(tg);
        p0 = o[1];
        tg = 0;
        h = '{default: 0};
        repeat (10) begin
            cyc(1);
            #1;
            foreach (h[i]) h[i] += (o[i] === 1'b1);
            tg += (o[1] !== p0);
            p0 = o[1];
        end
        chk({h[0], h[2]}, {32'd0, 32'd10});
        chk({h[3], tg}, {32'd3, 32'd1});
        $display("pwm test done");
    endtask : t_pwm

    // both-low gap between legs equals the dead time plus one
    task t_dead(input logic [7:0] d);
        int run;
        cyc(1);
        dead <= d;
        chm[0] <= CH_PWM;
        cmp[0] <= 16'ha;
        cfg(CNT_EDGE_UP, 16'h0, 16'h13);
        wupd(run);
        run = 0;
        repeat (60) begin
            cyc(1);
            #1 chk(o[0] & on[0], 1'b0);
            if (o[0] === 1'b0 && on[0] === 1'b0) run++;
            else begin
                if (run > 0) chk(run, d + 1);
                run = 0;
            end
        end
        $display("dead-time test done");
    endtask : t_dead

    // debug halt freezes the counter and forces outputs low
    task t_dbg;
        logic [15:0] v;
        cyc(1);
        cmp[2] <= 16'hffff;
        cyc(2);
        #1 chk(o[2], 1'b1);
        cyc(1);
        halt <= 1'b1;
        frz <= 1'b1;
        off <= 1'b1;
        cyc(2);
        #1 v = cnt;
        cyc(6);
        #1 chk({cnt, o, on}, {v, 8'h0});
        cyc(1);
        halt <= 1'b0;
        frz <= 1'b0;
        off <= 1'b0;
        cyc(3);
        #1 chk(cnt === v, 1'b0);
        $display("debug test done");
    endtask : t_dbg

    // capture latches the counter value before the sampling edge
    task t_cap;
        logic [15:0] v;
        int n;
        cyc(1);
        chm[0] <= CH_CAPTURE;
        cclr <= 4'hf;
        cyc(2);
        cclr <= 4'h0;
        fork
            i_src.pulse(0);
        join_none
        cyc(1);
        #1 v = cnt;
        n = 0;
        while (cf[0] !== 1'b1 && n < 4) begin
            cyc(1);
            #1 n++;
        end
        chk({cv[0], cf}, {v, 4'h1});
        cyc(1);
        cclr <= 4'h1;
        cyc(1);
        cclr <= 4'h0;
        #1 chk(cf, 4'h0);
        $display("capture test done");
    endtask : t_cap

    // link trigger edge zeroes the counter with no update
    task t_trig;
        cyc(1);
        trst <= 1'b1;
        rel <= 16'h0fff;
        cyc(30);
        fork
            i_src.pulse(4);
        join_none
        cyc(2);
        #1 chk({cnt, uevt}, 17'h0);
        $display("trigger test done");
    endtask : t_trig

    // five steps forward, two back
    task t_enc;
        logic [15:0] v;
        cyc(1);
        mode <= CNT_ENCODER;
        rel <= 16'h03e8;
        cyc(3);
        #1 v = cnt;
        repeat (5) i_src.step(1);
        repeat (2) i_src.step(-1);
        cyc(4);
        #1 chk(cnt, v + 16'h3);
        $display("encoder test done");
    endtask : t_enc

    // one-pulse stops at zero after the first wrap
    task t_one;
        int n;
        logic [15:0] v;
        cyc(1);
        one <= 1'b1;
        cfg(CNT_EDGE_UP, 16'h0, 16'h3);
        wupd(n);
        cyc(1);
        #1 v = cnt;
        n = 0;
        repeat (8) begin
            cyc(1);
            #1 n += (uevt === 1'b1);
        end
        chk({cnt, v, n[3:0]}, 36'h0);
        $display("one-pulse test done");
    endtask : t_one

    task results;
        $display("comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    // 10 mhz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // hang guard, far beyond the expected run
    initial begin
        #2_000_000;
        failures++;
        $display("wrong value at %0t ns: run timed out", $time);
        results();
    end

    // reset, then the scenarios in turn
    initial begin
        {arst_n, en, one, halt, frz, off, trst, uclr} = 8'h0;
        {irq_en, dma_en} = 2'b11;
        mode = CNT_EDGE_UP;
        chm = '{default: CH_OFF};
        {psc, rel, cmp, cclr, dead} = '0;
        failures = 0;
        comparisons = 0;
        cyc(20);
        #1 chk({cnt, upd, uevt, o, on, cf}, 30'h0);
        cyc(1);
        arst_n <= 1'b1;
        t_period();
        t_pwm();
        t_dead(8'h3);
        t_dead(8'h0);
        t_dbg();
        t_cap();
        t_trig();
        t_enc();
        t_one();
        results();
    end
endmodule : tb_top
